// file: rsr_pkg.sv
package rsr_pkg;

    // Instruction word and field widths, and the stack depth
    localparam int INSN_W = 16;
    localparam int NIB_W = 4;
    localparam int ADDR_W = 7;
    localparam int PC_W = 11;
    localparam int STACK_DEPTH = 8;
    localparam int WR_SEL_W = 4;

    // Opcode prefixes
    localparam logic [8:0] OP_ROTR = 9'h09B;
    localparam logic [8:0] OP_SUBM = 9'h014;
    localparam logic [8:0] OP_SUBMW = 9'h016;
    localparam logic [7:0] OP_SUBI = 8'h0E;
    localparam logic [7:0] OP_SUBIW = 8'h0F;
    localparam logic [13:0] OP_RET = 14'h0080;

    // Field positions
    localparam int PFX9_LSB = 7;
    localparam int PFX8_LSB = 8;
    localparam int RET_LSB = 2;
    localparam int IMM_LSB = 4;

    // Reset values
    localparam logic [NIB_W-1:0] ACC_RST = 4'h0;
    localparam logic [PC_W-1:0] PC_RST = 11'h000;

    // Working registers sit at the bottom of data memory
    localparam logic [ADDR_W-1:0] WR_BASE = 7'h00;

    typedef enum logic [5:0] {
        RSR_OP_NONE  = 6'b000001,
        RSR_OP_ROTR  = 6'b000010,
        RSR_OP_RET   = 6'b000100,
        RSR_OP_SUBM  = 6'b001000,
        RSR_OP_SUBMW = 6'b010000,
        RSR_OP_SUBI  = 6'b100000
    } rsr_op_t;

    typedef struct packed {
        logic carry_borrow_flag;
        logic zero_result_flag;
    } rsr_flags_t;

    typedef struct packed {
        logic we;
        logic [ADDR_W-1:0] addr;
        logic [NIB_W-1:0] data;
    } rsr_mem_wr_t;

endpackage

// file: rsr_data_mem.sv
`timescale 1ns/1ps
`default_nettype none

module rsr_data_mem #(
    parameter int DW = 4,
    parameter int AW = 7
) (
    // Clock
    input wire logic clock,
    // Read port
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data,
    // Write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data
);

    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end

endmodule

`default_nettype wire

// file: rsr_exec.sv
`timescale 1ns/1ps
`default_nettype none

module rsr_exec
    import rsr_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Instruction issue
    input wire logic insn_valid,
    input wire logic [INSN_W-1:0] insn,
    // Return stack top kept by the rest of the core
    input wire logic [PC_W-1:0] stack_top,
    // Data memory preload from the rest of the core
    input wire logic [$bits(rsr_mem_wr_t)-1:0] ext_wr,
    // Results
    output logic [NIB_W-1:0] acc,
    output logic [PC_W-1:0] program_counter,
    output logic carry_borrow_flag,
    output logic zero_result_flag,
    output logic stack_pop,
    output logic busy,
    output logic [$bits(rsr_mem_wr_t)-1:0] mem_wr
);

    // Decode of the opcode prefixes
    function automatic rsr_op_t decode_op(input logic [INSN_W-1:0] w);
        rsr_op_t op;
        op = RSR_OP_NONE;
        if (w[INSN_W-1:PFX9_LSB] == OP_ROTR) begin
            op = RSR_OP_ROTR;
        end else if (w[INSN_W-1:RET_LSB] == OP_RET) begin
            op = RSR_OP_RET;
        end else if (w[INSN_W-1:PFX9_LSB] == OP_SUBM) begin
            op = RSR_OP_SUBM;
        end else if (w[INSN_W-1:PFX9_LSB] == OP_SUBMW) begin
            op = RSR_OP_SUBMW;
        end else if (w[INSN_W-1:PFX8_LSB] == OP_SUBI || w[INSN_W-1:PFX8_LSB] == OP_SUBIW) begin
            op = RSR_OP_SUBI;
        end
        return op;
    endfunction

    // Operand address for a decoded word
    function automatic logic [ADDR_W-1:0] operand_addr(input logic [INSN_W-1:0] w);
        logic [ADDR_W-1:0] a;
        a = w[ADDR_W-1:0];
        if (w[INSN_W-1:PFX8_LSB] == OP_SUBI || w[INSN_W-1:PFX8_LSB] == OP_SUBIW) begin
            a = WR_BASE + {3'h0, w[WR_SEL_W-1:0]};
        end
        return a;
    endfunction

    typedef enum logic [1:0] {
        ST_FETCH = 2'b01,
        ST_EXEC  = 2'b10
    } rsr_state_t;

    rsr_mem_wr_t ext_wr_s;
    assign ext_wr_s = rsr_mem_wr_t'(ext_wr);

    // Pipeline and architectural state
    rsr_state_t state_reg, state_next;
    logic [INSN_W-1:0] insn_reg, insn_next;
    logic [NIB_W-1:0] acc_reg, acc_next;
    logic [PC_W-1:0] pc_reg, pc_next;
    rsr_flags_t flags_reg, flags_next;
    logic pop_reg, pop_next;
    rsr_mem_wr_t wr_reg, wr_next;
    logic [NIB_W-1:0] rd_data;

    rsr_op_t op_q;
    logic [NIB_W-1:0] imm_q;
    logic [NIB_W:0] diff;
    logic [NIB_W-1:0] res;

    // Read of the operand for the held instruction
    rsr_data_mem #(
        .DW(NIB_W),
        .AW(ADDR_W)
    ) u_mem (
        .clock(clock),
        .rd_addr(operand_addr(insn_next)),
        .rd_data(rd_data),
        .wr_en(wr_next.we),
        .wr_addr(wr_next.addr),
        .wr_data(wr_next.data)
    );

    always_comb begin
        op_q = decode_op(insn_reg);
        imm_q = insn_reg[IMM_LSB+NIB_W-1:IMM_LSB];
        state_next = state_reg;
        insn_next = insn_reg;
        acc_next = acc_reg;
        pc_next = pc_reg;
        flags_next = flags_reg;
        pop_next = 1'b0;
        wr_next = ext_wr_s;
        diff = '0;
        res = '0;
        case (state_reg)
            ST_FETCH: begin
                if (insn_valid) begin
                    insn_next = insn;
                    state_next = ST_EXEC;
                end
            end
            ST_EXEC: begin
                state_next = ST_FETCH;
                pc_next = pc_reg + 11'h001;
                case (op_q)
                    RSR_OP_ROTR: begin
                        res = {flags_reg.carry_borrow_flag, rd_data[NIB_W-1:1]};
                        flags_next.carry_borrow_flag = rd_data[0];
                        wr_next = '{we: 1'b1, addr: insn_reg[ADDR_W-1:0], data: res};
                    end
                    RSR_OP_RET: begin
                        pc_next = stack_top;
                        pop_next = 1'b1;
                    end
                    RSR_OP_SUBM, RSR_OP_SUBMW: begin
                        diff = {1'b0, rd_data} - {1'b0, acc_reg} - {4'h0, flags_reg.carry_borrow_flag};
                        res = diff[NIB_W-1:0];
                        flags_next.carry_borrow_flag = diff[NIB_W];
                        if (op_q == RSR_OP_SUBMW) begin
                            wr_next = '{we: 1'b1, addr: insn_reg[ADDR_W-1:0], data: res};
                        end
                    end
                    RSR_OP_SUBI: begin
                        diff = {1'b0, rd_data} - {1'b0, imm_q} - {4'h0, flags_reg.carry_borrow_flag};
                        res = diff[NIB_W-1:0];
                        flags_next.carry_borrow_flag = diff[NIB_W];
                        if (insn_reg[INSN_W-1:PFX8_LSB] == OP_SUBIW) begin
                            wr_next = '{we: 1'b1, addr: operand_addr(insn_reg), data: res};
                        end
                    end
                    default: begin
                    end
                endcase
                if (op_q != RSR_OP_NONE && op_q != RSR_OP_RET) begin
                    acc_next = res;
                    flags_next.zero_result_flag = (res == 4'h0);
                end
            end
            default: begin
                state_next = ST_FETCH;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ST_FETCH;
            insn_reg <= '0;
            acc_reg <= ACC_RST;
            pc_reg <= PC_RST;
            flags_reg <= '0;
            pop_reg <= 1'b0;
            wr_reg <= '0;
        end else begin
            state_reg <= state_next;
            insn_reg <= insn_next;
            acc_reg <= acc_next;
            pc_reg <= pc_next;
            flags_reg <= flags_next;
            pop_reg <= pop_next;
            wr_reg <= wr_next;
        end
    end

    assign acc = acc_reg;
    assign program_counter = pc_reg;
    assign carry_borrow_flag = flags_reg.carry_borrow_flag;
    assign zero_result_flag = flags_reg.zero_result_flag;
    assign stack_pop = pop_reg;
    // One-hot execute bit, straight from the state flop
    assign busy = state_reg[1];
    assign mem_wr = wr_reg;

endmodule

`default_nettype wire

// file: rsr_exec_checker.sv
`timescale 1ns/1ps
`default_nettype none

module rsr_exec_checker
    import rsr_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH
) (
    // Inputs of the block
    input wire logic clock,
    input wire logic rst_b,
    input wire logic insn_valid,
    input wire logic [INSN_W-1:0] insn,
    input wire logic [PC_W-1:0] stack_top,
    input wire logic [$bits(rsr_mem_wr_t)-1:0] ext_wr,
    // Outputs of the block
    input wire logic [NIB_W-1:0] acc,
    input wire logic [PC_W-1:0] program_counter,
    input wire logic carry_borrow_flag,
    input wire logic zero_result_flag,
    input wire logic stack_pop,
    input wire logic busy,
    input wire logic [$bits(rsr_mem_wr_t)-1:0] mem_wr
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);

    wire logic tk = insn_valid && !busy;
    wire logic is_rot = tk && insn[15:7] == OP_ROTR;
    wire logic is_ret = tk && insn[15:2] == OP_RET;
    wire logic is_subm = tk && insn[15:7] == OP_SUBM;
    wire logic is_submw = tk && insn[15:7] == OP_SUBMW;
    wire logic is_subiw = tk && insn[15:8] == OP_SUBIW;
    wire logic is_alu = is_rot || is_subm || is_submw || is_subiw || (tk && insn[15:8] == OP_SUBI);

    take_busy_a: assert property (tk |=> busy)
        else $error("request taken without busy");
    busy_once_a: assert property (busy |=> !busy)
        else $error("busy longer than one cycle");
    return_pc_a: assert property (is_ret ##1 busy |=> stack_pop && program_counter == $past(stack_top))
        else $error("return did not reload pc");
    rotate_store_a: assert property (is_rot ##1 busy |=> mem_wr[11] && mem_wr[10:4] == $past(insn[6:0], 2)
        && mem_wr[3:0] == acc)
        else $error("rotate result not stored");
    subm_only_a: assert property (is_subm ##1 busy |=> !mem_wr[11])
        else $error("plain subtract wrote memory");
    submw_store_a: assert property (is_submw ##1 busy |=> mem_wr[11] && mem_wr[10:4] == $past(insn[6:0], 2)
        && mem_wr[3:0] == acc)
        else $error("memory write-back wrong");
    subiw_store_a: assert property (is_subiw ##1 busy |=> mem_wr[11]
        && mem_wr[10:4] == {3'h0, $past(insn[3:0], 2)} && mem_wr[3:0] == acc)
        else $error("register write-back wrong");
    zero_flag_a: assert property (is_alu ##1 busy |=> zero_result_flag == (acc == 4'h0))
        else $error("zero flag disagrees with result");
endmodule

bind rsr_exec rsr_exec_checker #(.DEPTH(DEPTH)) u_chk (.clock(clock), .rst_b(rst_b), .insn_valid(insn_valid),
    .insn(insn), .stack_top(stack_top), .ext_wr(ext_wr), .acc(acc), .program_counter(program_counter),
    .carry_borrow_flag(carry_borrow_flag), .zero_result_flag(zero_result_flag), .stack_pop(stack_pop),
    .busy(busy), .mem_wr(mem_wr));

`default_nettype wire

// file: rsr_exec_bench.sv
`timescale 1ns/1ps
`default_nettype none

module rsr_exec_bench;
    import rsr_pkg::*;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic insn_valid = 1'b0;
    logic [15:0] insn = 16'h0000;
    logic [10:0] stack_top = 11'h000;
    logic [11:0] ext_wr = 12'h000;
    wire logic [3:0] acc;
    wire logic [10:0] pc;
    wire logic cf, zf, stack_pop, busy;
    wire logic [11:0] mem_wr;
    logic [3:0] mem [128];
    logic [3:0] e_acc = 4'h0;
    logic [10:0] e_pc = 11'h000;
    logic e_cf = 1'b0;
    logic e_zf = 1'b0;
    int errors = 0;
    int n_tests = 0;

    rsr_exec dut (.clock(clock), .rst_b(rst_b), .insn_valid(insn_valid), .insn(insn), .stack_top(stack_top),
        .ext_wr(ext_wr), .acc(acc), .program_counter(pc), .carry_borrow_flag(cf), .zero_result_flag(zf),
        .stack_pop(stack_pop), .busy(busy), .mem_wr(mem_wr));

    always #2 clock = ~clock;

    task automatic results();
        if (errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [4:0] sub(input logic [3:0] a, input logic [3:0] b, input logic c);
        return {1'b0, a} - {1'b0, b} - {4'h0, c};
    endfunction

    function automatic logic [15:0] pick(input int k, input logic [15:0] r);
        case (k)
            0: return {OP_ROTR, r[6:0]};
            1: return {OP_SUBM, r[6:0]};
            2: return {OP_SUBMW, r[6:0]};
            3: return {OP_SUBI, r[7:0]};
            4: return {OP_SUBIW, r[7:0]};
            5: return {OP_RET, 2'h0};
            default: return {8'hFF, r[7:0]};
        endcase
    endfunction

    task automatic run(input logic [15:0] w);
        logic [6:0] a;
        logic [4:0] d;
        logic we;
        logic ret;
        logic nop;
        ret = w == {OP_RET, 2'h0};
        nop = !ret && w[15:7] != OP_ROTR && w[15:7] != OP_SUBM && w[15:7] != OP_SUBMW && w[15:9] != 7'h07;
        a = w[6:0];
        we = w[8] && !nop;
        stack_top = 11'($urandom);
        d = sub(mem[a], e_acc, e_cf);
        if (w[15:7] == OP_ROTR) begin
            d = {mem[a][0], e_cf, mem[a][3:1]};
            we = 1'b1;
        end else if (w[15:9] == 7'h07) begin
            a = {3'h0, w[3:0]};
            d = sub(mem[a], w[7:4], e_cf);
        end
        if (ret) begin
            e_pc = stack_top;
        end else begin
            e_pc = e_pc + 11'h001;
            // Unknown codes only advance the program counter
            if (!nop) begin
                e_acc = d[3:0];
                e_cf = d[4];
                e_zf = d[3:0] == 4'h0;
            end
        end
        if (we)
            mem[a] = d[3:0];
        @(negedge clock);
        insn_valid = 1'b1;
        insn = w;
        @(negedge clock);
        // Stray request while busy must be ignored
        check(busy, 1'b1);
        insn_valid = 1'($urandom);
        insn = 16'($urandom);
        @(negedge clock);
        insn_valid = 1'b0;
        check(busy, 1'b0);
        check({acc, cf, zf, stack_pop, mem_wr[11], pc}, {e_acc, e_cf, e_zf, ret, we, e_pc});
        if (we)
            check(mem_wr, {we, a, d[3:0]});
    endtask

    initial begin
        void'($urandom(23157));
        repeat (4) @(posedge clock);
        @(negedge clock);
        rst_b = 1'b1;
        check({acc, pc, cf, zf, stack_pop, busy, mem_wr}, 32'h0);
        for (int i = 0; i < 128; i++) begin
            mem[i] = 4'($urandom);
            ext_wr = {1'b1, 7'(i), mem[i]};
            @(negedge clock);
        end
        ext_wr = 12'h000;
        for (int k = 0; k < 7; k++) begin
            run(pick(k, 16'h0000));
            run(pick(k, 16'hFFFF));
        end
        for (int i = 0; i < 300; i++)
            run(pick($urandom_range(0, 6), 16'($urandom)));
        results();
    end

    initial begin
        #20000;
        errors++;
        results();
    end
endmodule

`default_nettype wire
